// ### shared/timer_channel_pkg.sv
package timer_channel_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned CHANNELS   = 8;
  localparam int unsigned ADDR_WIDTH = 8;
  localparam int unsigned DATA_WIDTH = 8;
  localparam int unsigned SEL_WIDTH  = 2;
  localparam int unsigned MASTER_CH  = 7;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CAPTURE_COMPARE_SELECT = 8'h00;
  localparam logic [7:0] OFS_MASTER_MASK            = 8'h02;
  localparam logic [7:0] OFS_MASTER_DATA            = 8'h03;
  localparam logic [7:0] OFS_OUTPUT_ACTION_HIGH     = 8'h08;
  localparam logic [7:0] OFS_OUTPUT_ACTION_LOW      = 8'h09;
  localparam logic [7:0] OFS_CAPTURE_EDGE_HIGH      = 8'h0A;
  localparam logic [7:0] OFS_CAPTURE_EDGE_LOW       = 8'h0B;
  localparam logic [7:0] OFS_INTERRUPT_ENABLE       = 8'h0C;
  localparam logic [7:0] OFS_OUTPUT_PIN_DISCONNECT  = 8'h0D;
  localparam logic [7:0] OFS_EVENT_FLAGS            = 8'h0E;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REG    = 8'h00;
  localparam logic [7:0] READ_EMPTY = 8'h00;
  localparam logic [1:0] RST_SEL    = 2'h0;

  // ----------------------------------------------------------------
  // Selector encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACTION_NONE   = 2'b00,
    ACTION_TOGGLE = 2'b01,
    ACTION_CLEAR  = 2'b10,
    ACTION_SET    = 2'b11
  } output_action_e;

  localparam logic [1:0] EDGE_OFF     = 2'b00;
  localparam logic [1:0] EDGE_RISING  = 2'b01;
  localparam logic [1:0] EDGE_FALLING = 2'b10;
  localparam logic [1:0] EDGE_ANY     = 2'b11;

  // Pick the two-bit field of channel ch from a high/low register pair:
  // channels 7..4 in the high byte, 3..0 in the low byte, upper bit first.
  function automatic logic [1:0] pair_select(input logic [7:0] high_reg,
                                             input logic [7:0] low_reg,
                                             input int unsigned ch);
    logic [15:0] both;
    both = {high_reg, low_reg};
    return both[2 * ch +: 2];
  endfunction : pair_select

endpackage : timer_channel_pkg

// ### logic/channel_edge_detect.sv
`timescale 1ns/1ps

module channel_edge_detect (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       pin_in,
  input  wire logic [1:0] edge_select,
  output logic            capture_pulse
);

  logic meta;
  logic sync;
  logic prev;
  wire  rising;
  wire  falling;
  wire  next_capture;

  // ----------------------------------------------------------------
  // Synchroniser; meta feeds only sync
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin_in;
      sync <= meta;
      prev <= sync;
    end
  end

  // ----------------------------------------------------------------
  // Edge qualification
  // ----------------------------------------------------------------
  assign rising  = sync & ~prev;
  assign falling = ~sync & prev;
  assign next_capture = (edge_select == timer_channel_pkg::EDGE_RISING  && rising)  ||
                        (edge_select == timer_channel_pkg::EDGE_FALLING && falling) ||
                        (edge_select == timer_channel_pkg::EDGE_ANY && (rising || falling));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      capture_pulse <= 1'b0;
    end else begin
      capture_pulse <= next_capture;
    end
  end

endmodule : channel_edge_detect

// ### logic/timer_channel_action_control.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps

// Function
// - Eight two-bit output action selectors, mode bit over level bit, one per channel.
// - On compare: 00 nothing, 01 toggle, 10 drive low, 11 drive high.
// - Any selector bit set turns the channel pin into a compare-driven output; here only while the channel is in compare mode.
// - Own selector action only while the channel's master mask bit is clear; channels 6..0 also while master mask bit 7 is set.
// - Compare logic drives the pin only while its disconnect bit is clear.
// - Channel 7 own action only while master mask bit 7 is clear.
// - Masked channel takes master data on channel 7 match; on coinciding events the master data win.
// - Edge code 00 disables capture, 01 captures rising edges.
// - Edge code 10 captures falling edges only.
// - Edge code 11 captures every transition.
// - Edge selectors 7..4 at 0x0A, 3..0 at 0x0B, B above A, reset zero.
// - Eight interrupt enables at 0x0C, bit per event flag, reset zero.
// - A flag requests an interrupt only while its enable bit is one.
// - A channel's flag sets on each capture or compare event.
// - Writing one clears a flag while timer or accumulator enabled; zero leaves it.
module timer_channel_action_control #(
  parameter int unsigned CHANNELS = timer_channel_pkg::CHANNELS
) (
  input  wire logic                                      clk,
  input  wire logic                                      rstn,
  input  wire logic [timer_channel_pkg::ADDR_WIDTH-1:0]  addr,
  input  wire logic [timer_channel_pkg::DATA_WIDTH-1:0]  wdata,
  input  wire logic                                      wr,
  input  wire logic                                      rd,
  output logic      [timer_channel_pkg::DATA_WIDTH-1:0]  rdata,
  input  wire logic                                      timer_enable,
  input  wire logic                                      pacc_enable,
  input  wire logic [CHANNELS-1:0]                       compare_match,
  input  wire logic [CHANNELS-1:0]                       channel_pin_in,
  output logic      [CHANNELS-1:0]                       channel_pin_out,
  output logic      [CHANNELS-1:0]                       channel_pin_oe,
  output logic      [CHANNELS-1:0]                       capture_event,
  output logic      [CHANNELS-1:0]                       channel_irq,
  output logic                                           irq
);

  localparam int unsigned M = timer_channel_pkg::MASTER_CH;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [7:0] capture_or_compare_select;
  logic [7:0] master_compare_output_mask;
  logic [7:0] master_compare_output_data;
  logic [7:0] output_action_select_high;
  logic [7:0] output_action_select_low;
  logic [7:0] capture_edge_select_high;
  logic [7:0] capture_edge_select_low;
  logic [7:0] channel_interrupt_enable;
  logic [7:0] output_pin_disconnect;
  logic [7:0] channel_event_flags;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire hit_select   = (addr == timer_channel_pkg::OFS_CAPTURE_COMPARE_SELECT);
  wire hit_mask     = (addr == timer_channel_pkg::OFS_MASTER_MASK);
  wire hit_data     = (addr == timer_channel_pkg::OFS_MASTER_DATA);
  wire hit_act_high = (addr == timer_channel_pkg::OFS_OUTPUT_ACTION_HIGH);
  wire hit_act_low  = (addr == timer_channel_pkg::OFS_OUTPUT_ACTION_LOW);
  wire hit_edg_high = (addr == timer_channel_pkg::OFS_CAPTURE_EDGE_HIGH);
  wire hit_edg_low  = (addr == timer_channel_pkg::OFS_CAPTURE_EDGE_LOW);
  wire hit_enable   = (addr == timer_channel_pkg::OFS_INTERRUPT_ENABLE);
  wire hit_discon   = (addr == timer_channel_pkg::OFS_OUTPUT_PIN_DISCONNECT);
  wire hit_flags    = (addr == timer_channel_pkg::OFS_EVENT_FLAGS);

  wire wr_select   = wr & hit_select;
  wire wr_mask     = wr & hit_mask;
  wire wr_data     = wr & hit_data;
  wire wr_act_high = wr & hit_act_high;
  wire wr_act_low  = wr & hit_act_low;
  wire wr_edg_high = wr & hit_edg_high;
  wire wr_edg_low  = wr & hit_edg_low;
  wire wr_enable   = wr & hit_enable;
  wire wr_discon   = wr & hit_discon;
  wire wr_flags    = wr & hit_flags;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Plain storage; every selector is live on the clock after the write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      capture_or_compare_select  <= timer_channel_pkg::RST_REG;
      master_compare_output_mask <= timer_channel_pkg::RST_REG;
      master_compare_output_data <= timer_channel_pkg::RST_REG;
      output_action_select_high  <= timer_channel_pkg::RST_REG;
      output_action_select_low   <= timer_channel_pkg::RST_REG;
      capture_edge_select_high   <= timer_channel_pkg::RST_REG;
      capture_edge_select_low    <= timer_channel_pkg::RST_REG;
      channel_interrupt_enable   <= timer_channel_pkg::RST_REG;
      output_pin_disconnect      <= timer_channel_pkg::RST_REG;
    end else begin
      if (wr_select) begin
        capture_or_compare_select <= wdata;
      end
      if (wr_mask) begin
        master_compare_output_mask <= wdata;
      end
      if (wr_data) begin
        master_compare_output_data <= wdata;
      end
      if (wr_act_high) begin
        output_action_select_high <= wdata;
      end
      if (wr_act_low) begin
        output_action_select_low <= wdata;
      end
      if (wr_edg_high) begin
        capture_edge_select_high <= wdata;
      end
      if (wr_edg_low) begin
        capture_edge_select_low <= wdata;
      end
      if (wr_enable) begin
        channel_interrupt_enable <= wdata;
      end
      if (wr_discon) begin
        output_pin_disconnect <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped addresses read as zero; data stand only in the cycle after the strobe
  wire [7:0] read_mux =
    hit_select   ? capture_or_compare_select  :
    hit_mask     ? master_compare_output_mask :
    hit_data     ? master_compare_output_data :
    hit_act_high ? output_action_select_high  :
    hit_act_low  ? output_action_select_low   :
    hit_edg_high ? capture_edge_select_high   :
    hit_edg_low  ? capture_edge_select_low    :
    hit_enable   ? channel_interrupt_enable   :
    hit_discon   ? output_pin_disconnect      :
    hit_flags    ? channel_event_flags        :
                   timer_channel_pkg::READ_EMPTY;

  wire [7:0] next_rdata = rd ? read_mux : timer_channel_pkg::READ_EMPTY;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= timer_channel_pkg::READ_EMPTY;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Input capture edge detectors
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] capture_pulse;

  genvar gc;
  generate
    for (gc = 0; gc < CHANNELS; gc++) begin : g_capture
      wire [1:0] edge_sel = timer_channel_pkg::pair_select(capture_edge_select_high,
                                                            capture_edge_select_low, gc);
      channel_edge_detect u_edge (
        .clk           (clk),
        .rstn          (rstn),
        .pin_in        (channel_pin_in[gc]),
        .edge_select   (edge_sel),
        .capture_pulse (capture_pulse[gc])
      );
    end
  endgenerate

  // Only channels in capture mode report a capture
  wire [CHANNELS-1:0] capture_qualified = capture_pulse & ~capture_or_compare_select[CHANNELS-1:0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      capture_event <= '0;
    end else begin
      capture_event <= capture_qualified;
    end
  end

  // ----------------------------------------------------------------
  // Output compare actions
  // ----------------------------------------------------------------
  // The master only acts when channel 7 itself is in compare mode
  wire master_fire = compare_match[M] & capture_or_compare_select[M];

  logic [CHANNELS-1:0] compare_level;
  logic [CHANNELS-1:0] next_level;
  logic [CHANNELS-1:0] next_oe;
  logic [CHANNELS-1:0] compare_fire;

  genvar go;
  generate
    for (go = 0; go < CHANNELS; go++) begin : g_compare
      wire [1:0] act_code = timer_channel_pkg::pair_select(output_action_select_high,
                                                            output_action_select_low, go);
      wire       in_compare = capture_or_compare_select[go];
      wire       masked     = master_compare_output_mask[go];
      // Channel 7 gates itself; other masked channels keep their own action
      // only while channel 7 is also masked onto itself
      wire       own_allowed = (go == M) ? ~masked
                                         : (~masked | master_compare_output_mask[M]);
      wire       own_fire    = compare_match[go] & in_compare & own_allowed;
      wire       master_hit  = master_fire & masked & in_compare;
      logic      own_level;

      always_comb begin
        unique case (timer_channel_pkg::output_action_e'(act_code))
          timer_channel_pkg::ACTION_NONE:   own_level = compare_level[go];
          timer_channel_pkg::ACTION_TOGGLE: own_level = ~compare_level[go];
          timer_channel_pkg::ACTION_CLEAR:  own_level = 1'b0;
          timer_channel_pkg::ACTION_SET:    own_level = 1'b1;
        endcase
      end

      // Coinciding events: the master data win, since the pin cannot take both
      assign next_level[go] = master_hit ? master_compare_output_data[go] :
                              own_fire   ? own_level :
                                           compare_level[go];
      assign compare_fire[go] = compare_match[go] & in_compare;

      // A connected compare-mode pin becomes an output when a selector bit or the master mask claims it
      assign next_oe[go] = in_compare & ~output_pin_disconnect[go] &
                           ((|act_code) | masked);
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      compare_level  <= '0;
      channel_pin_oe <= '0;
    end else begin
      compare_level  <= next_level;
      channel_pin_oe <= next_oe;
    end
  end

  // Level tracks even while disconnected, so reconnecting shows the true state
  assign channel_pin_out = compare_level;

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  // Independent accumulator use relies on software leaving the selector at 00
  wire [7:0] flag_set   = {{(8 - CHANNELS){1'b0}}, compare_fire | capture_qualified};
  wire       clear_ok   = timer_enable | pacc_enable;
  wire [7:0] flag_clear = (wr_flags && clear_ok) ? wdata : timer_channel_pkg::RST_REG;
  // A set in the clearing cycle wins, so no event is lost
  wire [7:0] next_flags = flag_set | (channel_event_flags & ~flag_clear);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      channel_event_flags <= timer_channel_pkg::RST_REG;
    end else begin
      channel_event_flags <= next_flags;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  wire [CHANNELS-1:0] next_irq = channel_event_flags[CHANNELS-1:0] &
                                 channel_interrupt_enable[CHANNELS-1:0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      channel_irq <= '0;
      irq         <= 1'b0;
    end else begin
      channel_irq <= next_irq;
      irq         <= |next_irq;
    end
  end

endmodule : timer_channel_action_control

// ### tb/timer_channel_action_control_asserts.sv
`timescale 1ns/1ps

module timer_channel_action_control_asserts #(
  parameter int unsigned CHANNELS = timer_channel_pkg::CHANNELS
) (
  input wire logic                                     clk,
  input wire logic                                     rstn,
  input wire logic [timer_channel_pkg::ADDR_WIDTH-1:0] addr,
  input wire logic [timer_channel_pkg::DATA_WIDTH-1:0] wdata,
  input wire logic                                     wr,
  input wire logic                                     rd,
  input wire logic [timer_channel_pkg::DATA_WIDTH-1:0] rdata,
  input wire logic [CHANNELS-1:0]                      compare_match,
  input wire logic [CHANNELS-1:0]                      channel_pin_in,
  input wire logic [CHANNELS-1:0]                      channel_pin_out,
  input wire logic [CHANNELS-1:0]                      channel_pin_oe,
  input wire logic [CHANNELS-1:0]                      capture_event,
  input wire logic [CHANNELS-1:0]                      channel_irq,
  input wire logic                                     irq
);
  // ----------------------------------------------------------------
  // Shadow of the enable register, rebuilt from bus writes
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] enable_copy;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable_copy <= '0;
    end else if (wr && addr == timer_channel_pkg::OFS_INTERRUPT_ENABLE) begin
      enable_copy <= wdata[CHANNELS-1:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == timer_channel_pkg::READ_EMPTY)
    else $error("read data not empty outside a read answer");
  AST_ENABLE_READBACK: assert property (rd && addr == timer_channel_pkg::OFS_INTERRUPT_ENABLE
    |=> rdata[CHANNELS-1:0] == $past(enable_copy)) else $error("enable register read back wrong");
  AST_IRQ_NEEDS_ENABLE: assert property ((channel_irq & ~$past(enable_copy)) == '0)
    else $error("channel interrupt without its enable");
  AST_EVENT_TO_IRQ: assert property ((capture_event & enable_copy) != '0
    |=> (channel_irq & $past(capture_event & enable_copy)) == $past(capture_event & enable_copy))
    else $error("enabled capture did not raise its interrupt");
  AST_IRQ_IS_OR: assert property (irq == |channel_irq)
    else $error("summary interrupt differs from channel terms");
  AST_PIN_HOLDS: assert property ($past(compare_match) == '0 |-> $stable(channel_pin_out))
    else $error("compare output moved without a match");
  AST_OE_FOLLOWS_WRITE: assert property (!$past(wr) && !$past(wr, 2) |-> $stable(channel_pin_oe))
    else $error("output enable moved without a register write");
  AST_CAPTURE_NEEDS_EDGE: assert property (
    (capture_event & ~($past(channel_pin_in, 4) ^ $past(channel_pin_in, 5))) == '0)
    else $error("capture pulse without a pin transition");
endmodule : timer_channel_action_control_asserts

bind timer_channel_action_control timer_channel_action_control_asserts #(.CHANNELS(CHANNELS)) u_asserts (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .compare_match(compare_match), .channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out),
  .channel_pin_oe(channel_pin_oe), .capture_event(capture_event), .channel_irq(channel_irq), .irq(irq)
);

// ### tb/timer_pin_model.sv
`timescale 1ns/1ps

module timer_pin_model #(
  parameter int unsigned CHANNELS = timer_channel_pkg::CHANNELS
) (
  input  wire logic [CHANNELS-1:0] drive_level,
  input  wire logic [CHANNELS-1:0] pin_out,
  input  wire logic [CHANNELS-1:0] pin_oe,
  output logic      [CHANNELS-1:0] pin_level
);
  // Driven pins show the block's level; released pins show the outside source
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & drive_level);
endmodule : timer_pin_model

// ### tb/timer_channel_action_control_tb.sv
`timescale 1ns/1ps

module timer_channel_action_control_tb;
  logic       clk = 1'b0;
  logic       rstn, wr, rd, timer_enable, pacc_enable, irq;
  logic [7:0] addr, wdata, rdata, compare_match, channel_pin_in, ext_level;
  logic [7:0] channel_pin_out, channel_pin_oe, capture_event, channel_irq;
  int         err_count, tests_run, hits;
  logic [1:0] code_seq [5] = '{2'b11, 2'b00, 2'b10, 2'b01, 2'b01};
  logic       exp_seq  [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [7:0] reset_ofs [6] = '{timer_channel_pkg::OFS_OUTPUT_ACTION_HIGH, timer_channel_pkg::OFS_OUTPUT_ACTION_LOW,
    timer_channel_pkg::OFS_CAPTURE_EDGE_HIGH, timer_channel_pkg::OFS_CAPTURE_EDGE_LOW,
    timer_channel_pkg::OFS_INTERRUPT_ENABLE, 8'h05};

  timer_channel_action_control u_dut (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .timer_enable(timer_enable), .pacc_enable(pacc_enable), .compare_match(compare_match),
    .channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe),
    .capture_event(capture_event), .channel_irq(channel_irq), .irq(irq));
  timer_pin_model u_pins (.drive_level(ext_level), .pin_out(channel_pin_out), .pin_oe(channel_pin_oe),
    .pin_level(channel_pin_in));

  always #2 clk = ~clk;

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : bus_write

  task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check("rdata", exp, rdata);
  endtask : read_check

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic match(input logic [7:0] m);
    @(posedge clk);
    compare_match <= m;
    @(posedge clk);
    compare_match <= 8'h00;
    settle(1);
  endtask : match

  // Counts capture pulses of channel 1 after one edge; covers the sync delay
  task automatic edge_count(input logic level);
    @(posedge clk);
    ext_level[1] <= level;
    hits = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (capture_event[1] === 1'b1) hits++;
    end
  endtask : edge_count

  task automatic give_verdict();
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // Whole sequence is well under two thousand cycles; a hang is cut off far later
  initial begin
    #100000;
    err_count++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
    timer_enable = 1'b0; pacc_enable = 1'b0; compare_match = 8'h00; ext_level = 8'h00;
    err_count = 0; tests_run = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    foreach (reset_ofs[i]) read_check(reset_ofs[i], 8'h00);
    bus_write(timer_channel_pkg::OFS_CAPTURE_EDGE_HIGH, 8'hA5);
    bus_write(timer_channel_pkg::OFS_CAPTURE_EDGE_LOW, 8'h5A);
    read_check(timer_channel_pkg::OFS_CAPTURE_EDGE_HIGH, 8'hA5);
    read_check(timer_channel_pkg::OFS_CAPTURE_EDGE_LOW, 8'h5A);
    bus_write(timer_channel_pkg::OFS_CAPTURE_COMPARE_SELECT, 8'hFF);
    for (int i = 0; i < 5; i++) begin
      bus_write(timer_channel_pkg::OFS_OUTPUT_ACTION_LOW, {6'h00, code_seq[i]});
      match(8'h01);
      check("pin_out", {7'h00, exp_seq[i]}, channel_pin_out);
      check("pin_oe", {7'h00, |code_seq[i]}, channel_pin_oe);
    end
    check("channel_irq", 8'h00, channel_irq);
    read_check(timer_channel_pkg::OFS_EVENT_FLAGS, 8'h01);
    bus_write(timer_channel_pkg::OFS_INTERRUPT_ENABLE, 8'h01);
    settle(1);
    check("irq", 8'h01, {channel_irq[7:1], irq});
    bus_write(timer_channel_pkg::OFS_EVENT_FLAGS, 8'h01);
    read_check(timer_channel_pkg::OFS_EVENT_FLAGS, 8'h01);
    @(posedge clk);
    timer_enable <= 1'b1;
    bus_write(timer_channel_pkg::OFS_EVENT_FLAGS, 8'h00);
    read_check(timer_channel_pkg::OFS_EVENT_FLAGS, 8'h01);
    bus_write(timer_channel_pkg::OFS_EVENT_FLAGS, 8'h01);
    read_check(timer_channel_pkg::OFS_EVENT_FLAGS, 8'h00);
    check("irq_cleared", 8'h00, {channel_irq[7:1], irq});
    bus_write(timer_channel_pkg::OFS_OUTPUT_ACTION_LOW, 8'h03);
    bus_write(timer_channel_pkg::OFS_OUTPUT_PIN_DISCONNECT, 8'h01);
    settle(1);
    check("oe_disconnect", 8'h00, channel_pin_oe);
    bus_write(timer_channel_pkg::OFS_OUTPUT_PIN_DISCONNECT, 8'h00);
    settle(1);
    check("oe_reconnect", 8'h01, channel_pin_oe);
    bus_write(timer_channel_pkg::OFS_MASTER_MASK, 8'h01);
    bus_write(timer_channel_pkg::OFS_MASTER_DATA, 8'h00);
    match(8'h01);
    check("masked_own", 8'h00, channel_pin_out);
    bus_write(timer_channel_pkg::OFS_MASTER_DATA, 8'h01);
    match(8'h80);
    check("master_data", 8'h01, channel_pin_out);
    bus_write(timer_channel_pkg::OFS_OUTPUT_ACTION_HIGH, 8'hC0);
    bus_write(timer_channel_pkg::OFS_MASTER_MASK, 8'h81);
    bus_write(timer_channel_pkg::OFS_MASTER_DATA, 8'h00);
    match(8'h80);
    check("master_self", 8'h00, channel_pin_out);
    bus_write(timer_channel_pkg::OFS_MASTER_MASK, 8'h00);
    match(8'h80);
    check("own_ch7", 8'h80, channel_pin_out);
    @(posedge clk);
    timer_enable <= 1'b0;
    pacc_enable  <= 1'b1;
    bus_write(timer_channel_pkg::OFS_EVENT_FLAGS, 8'hFF);
    read_check(timer_channel_pkg::OFS_EVENT_FLAGS, 8'h00);
    bus_write(timer_channel_pkg::OFS_CAPTURE_COMPARE_SELECT, 8'h00);
    bus_write(timer_channel_pkg::OFS_INTERRUPT_ENABLE, 8'h02);
    for (int c = 0; c < 4; c++) begin
      bus_write(timer_channel_pkg::OFS_CAPTURE_EDGE_LOW, {4'h0, 2'(c), 2'b00});
      edge_count(1'b1);
      check("rise_hits", {7'h00, 1'(c)}, 8'(hits));
      edge_count(1'b0);
      check("fall_hits", {7'h00, 1'(c >> 1)}, 8'(hits));
    end
    check("capture_irq", 8'h02, channel_irq);
    give_verdict();
  end
endmodule : timer_channel_action_control_tb
